// ### mic_apb_slave.sv
// APB slave decode and read mux for the memory init control registers.
`timescale 1ns/1ps
module mic_apb_slave (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] ctrl_q,
    input wire logic [31:0] data_q,
    output logic wr_ctrl,
    output logic wr_data,
    output logic [31:0] rd_data,
    output logic rd_err
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Access phase strobes; while the clock enable is high the slave answers with no wait.
    wire logic access = psel & penable;
    wire logic hit_ctrl = paddr == mic_pkg::MEMORY_INIT_CONTROL_OFF;
    wire logic hit_data = paddr == mic_pkg::DEVICE_REGISTER_DATA_OFF;
    assign wr_ctrl = access & pwrite & hit_ctrl;
    assign wr_data = access & pwrite & hit_data;
    assign rd_err = ~(hit_ctrl | hit_data);
    // Reserved control bits read zero.
    assign rd_data = hit_ctrl ? (ctrl_q & mic_pkg::CTRL_WMASK) :
                     hit_data ? data_q : 32'h0000_0000;
endmodule

// ### mic_chk.sv
// Checker for the ports of the memory init control bank.
`timescale 1ns/1ps
module mic_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [1:0] op_channel,
    input wire logic op_broadcast,
    input wire logic [4:0] op_device,
    input wire logic swap_b_q,
    input wire logic op_ack
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] since_q;
    // Decode of setup cycles, mapped offsets and completed control writes.
    wire setup = psel && !penable;
    wire mapped = paddr == 8'h90 || paddr == 8'h94;
    wire wr_ctl = psel && penable && pready && pwrite && paddr == 8'h94;
    // Counts cycles since the last launch write, saturating at seven.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_q <= 3'h7;
        else if (wr_ctl && pwdata[23]) since_q <= 3'h0;
        else if (since_q != 3'h7) since_q <= since_q + 3'h1;
    end
    a_map_ok: assert property (setup && mapped |=>
        pready && !pslverr)
        else $error("mapped access not answered cleanly");
    a_map_err: assert property (setup && !mapped && !pwrite |=>
        pready && pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_rsvd_zero: assert property (pready && psel && !pwrite &&
        paddr == 8'h94 |-> (prdata & ~mic_pkg::CTRL_WMASK) == 32'h0)
        else $error("reserved control bits read nonzero");
    a_op_start: assert property ($rose(op_valid) |->
        since_q inside {[3'h1:3'h3]})
        else $error("op request without launch write");
    a_op_hold: assert property (op_valid && !op_ack |=> op_valid &&
        $stable({op_code, op_channel, op_device, op_broadcast}))
        else $error("op request changed before ack");
    a_op_drop: assert property (op_valid && op_ack |=> !op_valid)
        else $error("op request held after ack");
    a_bcast_dev: assert property (op_valid && op_broadcast |->
        op_device == 5'h00)
        else $error("broadcast op carries a device address");
    a_swap_src: assert property ($changed(swap_b_q) |->
        $past(wr_ctl) || $past(wr_ctl, 2))
        else $error("swap flag moved without control write");
endmodule
bind mic_top mic_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code,
    .op_channel, .op_broadcast, .op_device, .swap_b_q, .op_ack);

// ### mic_mem_model.sv
// Behavioural memory channel that acknowledges op requests.
`timescale 1ns/1ps
module mic_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic op_valid,
    input wire logic [7:0] dly,
    input wire logic [15:0] da,
    input wire logic [15:0] db,
    output logic op_ack,
    output logic [15:0] op_rdata_a,
    output logic [15:0] op_rdata_b
);
    logic [7:0] cnt_q;
    wire hit = op_valid && cnt_q == dly;
    // Acks once after dly cycles; read data toggles outside the ack.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            op_ack <= 1'b0;
            op_rdata_a <= 16'h5a5a;
            op_rdata_b <= 16'ha5a5;
        end else begin
            cnt_q <= op_valid ? cnt_q + 8'h01 : 8'h00;
            op_ack <= hit;
            op_rdata_a <= hit ? da : ~op_rdata_a;
            op_rdata_b <= hit ? db : ~op_rdata_b;
        end
    end
endmodule

// ### mic_pkg.sv
// Package of constants for the memory init control register bank.
package mic_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DEVICE_REGISTER_DATA_OFF = 8'h90;
    localparam logic [7:0] MEMORY_INIT_CONTROL_OFF = 8'h94;
    localparam logic [31:0] MEMORY_INIT_CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] DEVICE_REGISTER_DATA_RST = 32'h0000_0000;
    // Writable bits of the control register; the rest read zero.
    localparam logic [31:0] CTRL_WMASK = 32'h79bf_ffff;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SWAP_BIT = 30;
    localparam int PUW_LSB = 28;
    localparam int DONE_BIT = 27;
    localparam int HUB_BIT = 24;
    localparam int LAUNCH_BIT = 23;
    localparam int CHAN_LSB = 20;
    localparam int BCAST_BIT = 19;
    localparam int DRA_LSB = 10;
    localparam int SDA_LSB = 5;
    localparam int OPC_LSB = 0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    // Power-down exit times in tenths of a microsecond.
    localparam int PUW_T0_DUS = 420;
    localparam int PUW_T1_DUS = 345;
    localparam int PUW_T2_DUS = 270;
    localparam int PUW_T3_DUS = 195;
    localparam int PUW_C0 = PUW_T0_DUS * CLK_MHZ / 10;
    localparam int PUW_C1 = PUW_T1_DUS * CLK_MHZ / 10;
    localparam int PUW_C2 = PUW_T2_DUS * CLK_MHZ / 10;
    localparam int PUW_C3 = PUW_T3_DUS * CLK_MHZ / 10;
    localparam int CNT_W = 12;
    // Register read opcode, and the opcode that exits power-down and so needs the long wait.
    localparam logic [4:0] OPC_REG_READ = 5'h00;
    localparam logic [4:0] OPC_PDN_EXIT = 5'h11;
    // Serial op sequencer states.
    typedef enum logic [1:0] {
        MIC_IDLE = 2'b00,
        MIC_SEND = 2'b01,
        MIC_WAIT = 2'b10,
        MIC_DONE = 2'b11
    } mic_state_t;
endpackage

// ### mic_top.sv
// Memory init control register bank with its op sequencer.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
// Functional notes
// R1: Bit 30 swaps hub stick channels, interface two.
// R2: Bits 29:28 pick power-down exit wait time.
// R3: Software sets init done flag when finished.
// R4: Software sets hub present flag when detected.
// R5: Software checks launch bit zero before launching.
// R6: Writing launch one starts the selected operation.
// R7: Launch bit self-clears when operation completes.
// R8: Read data valid when launch bit clears.
// R9: Bits 21:20 steer operation to a channel.
// R10: Bits 4:0 select the initialization operation.
// R11: Broadcast bit targets all devices, ignores address.
// R12: Data high half first interface, low second.
// R13: Reserved bits read zero, writes ignored.
module mic_top #(
    parameter int OP_CYCLES = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory channel side of the sequencer.
    output logic op_valid,
    output logic [4:0] op_code,
    output logic [1:0] op_channel,
    output logic op_broadcast,
    output logic [4:0] op_device,
    output logic [8:0] op_reg_addr,
    output logic [15:0] op_wdata_a,
    output logic [15:0] op_wdata_b,
    output logic swap_b_q,
    output logic init_done_q,
    output logic hub_present_q,
    input wire logic op_ack,
    input wire logic [15:0] op_rdata_a,
    input wire logic [15:0] op_rdata_b
);
    // Next values and qualified strobes.
    logic [7:0] op_cnt_d;
    logic ctrl_wr_ok;
    logic [31:0] ctrl_wval;
    logic capture;
    logic data_wr_ok;
    logic setup;
    logic [4:0] dev_d;
    logic [31:0] ctrl_q;
    logic [31:0] data_q;
    logic [31:0] rd_data;
    logic wr_ctrl;
    logic wr_data;
    logic rd_err;
    logic tmr_busy;
    logic tmr_load;
    logic [mic_pkg::CNT_W-1:0] tmr_val;
    logic [7:0] op_cnt_q;
    mic_pkg::mic_state_t state_q;
    mic_pkg::mic_state_t state_d;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    mic_apb_slave u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .ctrl_q(ctrl_q),
        .data_q(data_q),
        .wr_ctrl(wr_ctrl),
        .wr_data(wr_data),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Fields of the control register.
    wire logic launch = ctrl_q[mic_pkg::LAUNCH_BIT];
    wire logic [1:0] puw = ctrl_q[mic_pkg::PUW_LSB +: 2];
    wire logic [4:0] opc = ctrl_q[mic_pkg::OPC_LSB +: 5];
    wire logic bcast = ctrl_q[mic_pkg::BCAST_BIT];
    // Idle state, and the edge at which the channel takes the op.
    wire logic idle = state_q == mic_pkg::MIC_IDLE;
    wire logic acked = (state_q == mic_pkg::MIC_SEND) & op_ack;
    wire logic finish = state_q == mic_pkg::MIC_DONE;
    wire logic needs_wait = opc == mic_pkg::OPC_PDN_EXIT;

    // Wait length for the power-down exit field.
    function automatic logic [mic_pkg::CNT_W-1:0] puw_cycles(
        input logic [1:0] sel
    );
        unique case (sel)
            2'b00: puw_cycles = mic_pkg::CNT_W'(mic_pkg::PUW_C0);
            2'b01: puw_cycles = mic_pkg::CNT_W'(mic_pkg::PUW_C1);
            2'b10: puw_cycles = mic_pkg::CNT_W'(mic_pkg::PUW_C2);
            2'b11: puw_cycles = mic_pkg::CNT_W'(mic_pkg::PUW_C3);
        endcase
    endfunction

    assign tmr_val = puw_cycles(puw); // see R2
    // Only a power-down exit loads the timer, on the ack edge, so the
    // wait is measured from the moment the channel took the op.
    assign tmr_load = ce & acked & needs_wait;

    mic_wait_timer #(.W(mic_pkg::CNT_W)) u_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(tmr_load),
        .load_val(tmr_val),
        .busy(tmr_busy)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Send the op, wait for the channel to ack, then for the exit
    // time or a settle count, then drop the launch bit.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mic_pkg::MIC_IDLE: begin
                if (launch) begin
                    state_d = mic_pkg::MIC_SEND; // see R6
                end
            end
            mic_pkg::MIC_SEND: begin
                if (op_ack) begin
                    state_d = mic_pkg::MIC_WAIT;
                end
            end
            mic_pkg::MIC_WAIT: begin
                if (!tmr_busy && !tmr_load && op_cnt_q == 8'h00) begin
                    state_d = mic_pkg::MIC_DONE;
                end
            end
            mic_pkg::MIC_DONE: begin
                state_d = mic_pkg::MIC_IDLE;
            end
        endcase
    end

    // State register; it only moves while the clock enable is high,
    // so a frozen clock enable holds the current step, but an op_ack pulse that comes while it is low is missed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= mic_pkg::MIC_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // Settle count: reloaded on the ack, then runs down to zero.
    assign op_cnt_d = acked ? 8'(OP_CYCLES) :
                      (op_cnt_q != 8'h00) ? op_cnt_q - 8'h01 : op_cnt_q;

    // Settle counter register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_cnt_q <= 8'h00;
        end else if (ce) begin
            op_cnt_q <= op_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // A control write lands only while idle; a write that arrives
    // while an operation runs is dropped whole, so a late write
    // cannot change the opcode or target under the channel.
    assign ctrl_wr_ok = wr_ctrl & idle & ~launch;
    // Reserved bits are cleared before they can be stored.
    assign ctrl_wval = pwdata & mic_pkg::CTRL_WMASK; // see R13

    // Control register: masked writes, launch held until done.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= mic_pkg::MEMORY_INIT_CONTROL_RST;
        end else if (ce) begin
            if (ctrl_wr_ok) begin
                ctrl_q <= ctrl_wval;
            end else if (finish) begin
                ctrl_q[mic_pkg::LAUNCH_BIT] <= 1'b0; // see R7
            end
        end
    end

    // Read data is captured on the ack of a register read, so it is
    // in place well before the launch bit drops.
    assign capture = acked & (opc == mic_pkg::OPC_REG_READ);
    // Software may load the data word only while no op is running,
    // so the write data handed to the channel stays put.
    assign data_wr_ok = wr_data & ~launch;

    // Data register: channel A in the high half, B in the low half.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= mic_pkg::DEVICE_REGISTER_DATA_RST;
        end else if (ce) begin
            if (capture) begin
                data_q <= {op_rdata_a, op_rdata_b}; // see R8, R12
            end else if (data_wr_ok) begin
                data_q <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // While the clock enable is high every access completes in two cycles:
    // ready is raised for the access phase that follows each setup cycle.
    assign setup = psel & ~penable;

    // Handshake flags of the bus answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup & rd_err;
        end
    end

    // Read data, sampled in the setup cycle and held for the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            prdata <= rd_data;
        end
    end

    // ------------------------------------------------------------
    // Op request
    // ------------------------------------------------------------
    // Broadcast ignores the device address.
    assign dev_d = bcast ? 5'h00 : ctrl_q[mic_pkg::SDA_LSB +: 5]; // see R11

    // Request valid rises with the send state and falls on the ack when the
    // clock enable is high; an ack that comes while the enable is low leaves the request up.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_valid <= 1'b0;
        end else if (ce) begin
            op_valid <= state_d == mic_pkg::MIC_SEND;
        end
    end

    // Request fields; they follow the control register, which is
    // frozen while an operation runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_code <= 5'h00;
            op_channel <= 2'b00;
            op_broadcast <= 1'b0;
            op_device <= 5'h00;
            op_reg_addr <= 9'h000;
        end else if (ce) begin
            op_code <= opc; // see R10
            op_channel <= ctrl_q[mic_pkg::CHAN_LSB +: 2]; // see R9
            op_broadcast <= bcast;
            op_device <= dev_d;
            op_reg_addr <= ctrl_q[mic_pkg::DRA_LSB +: 9];
        end
    end

    // Write data halves for the two interfaces.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_wdata_a <= 16'h0000;
            op_wdata_b <= 16'h0000;
        end else if (ce) begin
            op_wdata_a <= data_q[31:16]; // see R12
            op_wdata_b <= data_q[15:0];
        end
    end

    // ------------------------------------------------------------
    // Mirrored flags
    // ------------------------------------------------------------
    // Copies of the software-owned bits for the channel logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swap_b_q <= 1'b0;
            init_done_q <= 1'b0;
            hub_present_q <= 1'b0;
        end else if (ce) begin
            swap_b_q <= ctrl_q[mic_pkg::SWAP_BIT]; // see R1
            init_done_q <= ctrl_q[mic_pkg::DONE_BIT]; // see R3
            hub_present_q <= ctrl_q[mic_pkg::HUB_BIT]; // see R4
        end
    end
endmodule

// ### mic_top_tb_top.sv
// Self-checking bench for the memory init control bank.
`timescale 1ns/1ps
module mic_top_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, dly = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, v;
    logic [15:0] da = 16'h0, db = 16'h0, op_rdata_a, op_rdata_b;
    logic pready, pslverr, op_valid, op_broadcast, swap_b_q, op_ack;
    logic init_done_q, hub_present_q, ov_q = 0;
    logic [4:0] op_code, op_device, opc;
    logic [1:0] op_channel, power_up_wait_time;
    logic [8:0] op_reg_addr;
    logic [15:0] op_wdata_a, op_wdata_b;
    logic [31:0] wd = 32'h0;
    logic [64:0] rd_q[$];
    logic [53:0] op_q[$];
    int mismatches = 0, n_compared = 0, cyc = 0, t_ack = 0, seed, lo;
    int tw[4] = '{1050, 862, 675, 487};
    mic_top #(.OP_CYCLES(2)) dut (.pclk, .presetn, .ce(1'b1), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .op_valid, .op_code, .op_channel, .op_broadcast, .op_device,
        .op_reg_addr, .op_wdata_a, .op_wdata_b, .swap_b_q,
        .init_done_q, .hub_present_q, .op_ack, .op_rdata_a, .op_rdata_b);
    mic_mem_model mem (.pclk, .presetn, .op_valid, .dly, .da, .db,
        .op_ack, .op_rdata_a, .op_rdata_b);
    // Op request as the channel sees it, in the layout of the notes.
    wire [53:0] op_now = {op_code, op_channel, op_broadcast, op_device,
        op_reg_addr, op_wdata_a, op_wdata_b};
    // Free-running clock.
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic final_report();
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // One APB transfer; read data lands in r at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        r = prdata;
        psel <= 0;
        penable <= 0;
        chk(n < 40, "no ready");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, m,
        input logic e);
        rd_q.push_back({e, m, x});
        apb(0, a, 32'h0);
    endtask
    // Polls the control register until the launch bit reads zero.
    task automatic wait_idle();
        int k = 0;
        do begin
            rd(8'h94, 32'h0, 32'h0, 1'b0);
            k++;
        end while (r[23] !== 1'b0 && k < 2000);
        chk(k < 2000, "launch stuck");
    endtask
    // Monitor: compares each read and each new op with the oldest note.
    always @(posedge pclk) begin
        logic [64:0] e;
        cyc++;
        if (op_ack === 1'b1) t_ack = cyc;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = rd_q.pop_front();
            chk(pslverr === e[64] && (prdata & e[63:32]) ===
                (e[31:0] & e[63:32]), "read data");
        end
        if (op_valid === 1'b1 && !ov_q)
            chk(op_now === op_q.pop_front(), "op");
        ov_q <= op_valid;
    end
    initial begin
        seed = $urandom(67871);
        repeat (5) @(posedge pclk);
        presetn <= 1;
        rd(8'h94, 32'h0, '1, 0);
        rd(8'h90, 32'h0, '1, 0);
        rd(8'h98, 32'h0, '1, 1);
        v = $urandom;
        apb(1, 8'h90, v);
        rd(8'h90, v, '1, 0);
        wd = v;
        v = $urandom & ~32'h0080_0000;
        apb(1, 8'h94, v);
        rd(8'h94, v & mic_pkg::CTRL_WMASK, '1, 0);
        chk(swap_b_q === v[30], "swap flag");
        chk(init_done_q === v[27], "done flag");
        chk(hub_present_q === v[24], "hub flag");
        // Two register reads, then a timed exit for every wait code.
        for (int i = 0; i < 6; i++) begin
            opc = (i < 2) ? 5'h00 : 5'h11;
            power_up_wait_time = 2'(i + 2);
            dly <= 8'($urandom % 6);
            da <= 16'($urandom);
            db <= 16'($urandom);
            v = ($urandom & 32'h4907_ffe0) | 32'h0080_0000 | opc |
                {2'b0, power_up_wait_time, 28'h0} | {10'h0, 2'(i), 20'h0} |
                {12'h0, i == 1, 19'h0};
            op_q.push_back({opc, 2'(i), i == 1, i == 1 ? 5'h0 : v[9:5],
                v[18:10], wd});
            apb(1, 8'h94, v);
            apb(1, 8'h94, 32'h0);
            wait_idle();
            lo = cyc - t_ack - ((i < 2) ? 3 : tw[2'(i - 2)]);
            chk(lo >= 0 && lo <= 10, "wait");
            v[23] = 1'b0;
            rd(8'h94, v & mic_pkg::CTRL_WMASK, '1, 0);
            if (i < 2) begin
                rd(8'h90, {da, db}, '1, 0);
                wd = {da, db};
            end
        end
        final_report();
    end
    // Watchdog against a hung handshake.
    initial begin
        #2000000;
        mismatches++;
        final_report();
    end
endmodule

// ### mic_wait_timer.sv
// Down counter that times the power-down exit wait.
`timescale 1ns/1ps
module mic_wait_timer #(
    parameter int W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy
);
    logic [W-1:0] cnt_q;
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Loads on request, counts down to zero while enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (load) begin
                cnt_q <= load_val;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end
    assign busy = cnt_q != '0;
endmodule
